//--- hdl/npc_pkg.sv
// Package for the flash program and erase controller.
// Assumes a 32-bit APB register bus and one 125 MHz system clock.
package npc_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [11:0] OFS_ADDR_LOW = 12'h000;
  localparam logic [11:0] OFS_ADDR_HIGH = 12'h004;
  localparam logic [11:0] OFS_OP_CONTROL = 12'h008;
  localparam logic [11:0] OFS_UNLOCK_KEY = 12'h00C;
  localparam logic [11:0] OFS_DATA_LOW = 12'h010;
  localparam logic [11:0] OFS_DATA_HIGH = 12'h014;

  // Field positions inside the operation control register.
  localparam int BIT_CFG_SEL = 6;
  localparam int BIT_LATCH_ONLY = 5;
  localparam int BIT_ERASE_EN = 4;
  localparam int BIT_ERROR = 3;
  localparam int BIT_PROG_EN = 2;
  localparam int BIT_WRITE_START = 1;
  localparam int BIT_READ_START = 0;

  // Array geometry.
  localparam int ADDR_W = 15;
  localparam int WORD_W = 14;
  localparam int ROW_WORDS = 32;
  localparam int ROW_IDX_W = 5;

  // Unlock pattern and reset values.
  localparam logic [7:0] KEY_FIRST_VAL = 8'h55;
  localparam logic [7:0] KEY_SECOND_VAL = 8'hAA;
  localparam logic [WORD_W-1:0] LATCH_RESET_VAL = 14'h03FF;
  localparam logic [7:0] ADDR_LOW_RESET = 8'h00;
  localparam logic [6:0] ADDR_HIGH_RESET = 7'h00;
  localparam logic [7:0] DATA_LOW_RESET = 8'h00;
  localparam logic [5:0] DATA_HIGH_RESET = 6'h00;

  // Commands presented to the flash array.
  localparam logic [1:0] CMD_NONE = 2'h0;
  localparam logic [1:0] CMD_READ = 2'h1;
  localparam logic [1:0] CMD_ERASE = 2'h2;
  localparam logic [1:0] CMD_ROW_WRITE = 2'h3;

  typedef logic [ROW_WORDS-1:0][WORD_W-1:0] npc_row_t;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_ERASE, ST_ROW} npc_state_t;
  typedef enum logic [1:0] {KEY_IDLE, KEY_FIRST, KEY_ARMED} npc_key_t;

endpackage

//--- hdl/npc_nvm_ctrl.sv
// Flash program and erase controller with an APB register slave.
// Assumes a flash array that pulses flashDone once while flashReq is held,
// and protection logic that reports the addressed location as protected.

module npc_nvm_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash array
  output logic flashReq,
  output logic [1:0] flashCmd,
  output logic flashCfgSpace,
  output logic [npc_pkg::ADDR_W-1:0] flashAddr,
  output npc_pkg::npc_row_t flashRowData,
  input wire logic flashDone,
  input wire logic [npc_pkg::WORD_W-1:0] flashRdData,
  // Protection and reset history
  input wire logic writeProtect,
  input wire logic writeAbortedAtReset
);

  import npc_pkg::*;

  logic [7:0] adrLow_ff;
  logic [6:0] adrHigh_ff;
  logic cfgSel_ff;
  logic latchOnly_ff;
  logic eraseEn_ff;
  logic error_ff;
  logic progEn_ff;
  logic writeStart_ff;
  logic readStart_ff;
  logic [7:0] datLow_ff;
  logic [5:0] datHigh_ff;
  npc_state_t state_ff;
  npc_key_t key_ff;
  npc_key_t nxt_key;
  npc_row_t latch_ff;
  logic firstCycle_ff;
  logic flashReq_ff;
  logic [1:0] flashCmd_ff;
  logic flashCfg_ff;
  logic [ADDR_W-1:0] flashAddr_ff;
  logic [31:0] prdata_ff;
  logic keyAbort;

  // Registers decode on word addresses; byte lanes are ignored.
  function automatic logic hitAt(input logic [11:0] a,
                                 input logic [11:0] ofs);
    hitAt = (a[11:2] == ofs[11:2]);
  endfunction

  // Bus decode.
  wire apbAccess = psel & penable;
  wire apbWrite = apbAccess & pwrite;
  wire apbSetupRead = psel & ~penable & ~pwrite;
  wire hitAdrLow = hitAt(paddr, OFS_ADDR_LOW);
  wire hitAdrHigh = hitAt(paddr, OFS_ADDR_HIGH);
  wire hitCtrl = hitAt(paddr, OFS_OP_CONTROL);
  wire hitKey = hitAt(paddr, OFS_UNLOCK_KEY);
  wire hitDatLow = hitAt(paddr, OFS_DATA_LOW);
  wire hitDatHigh = hitAt(paddr, OFS_DATA_HIGH);
  wire mapped = hitAdrLow | hitAdrHigh | hitCtrl | hitKey | hitDatLow
    | hitDatHigh;
  wire wrCtrl = apbWrite & hitCtrl;
  wire wrKey = apbWrite & hitKey;
  wire busy = (state_ff != ST_IDLE);
  wire [ROW_IDX_W-1:0] latchIdx = adrLow_ff[ROW_IDX_W-1:0];

  always_comb
  begin
    nxt_key = key_ff;
    keyAbort = 1'b0;
    if (apbAccess)
    begin
      case (key_ff)
        KEY_IDLE:
        begin
          // A wrong first key is ignored rather than flagged.
          if (wrKey && pwdata[7:0] == KEY_FIRST_VAL)
            nxt_key = KEY_FIRST;
        end
        KEY_FIRST:
        begin
          if (wrKey && pwdata[7:0] == KEY_SECOND_VAL)
            nxt_key = KEY_ARMED;
          else
          begin
            nxt_key = KEY_IDLE;
            keyAbort = 1'b1;
          end
        end
        KEY_ARMED:
        begin
          // Only a write start may follow
          nxt_key = KEY_IDLE;
          keyAbort = ~(wrCtrl & pwdata[BIT_WRITE_START]);
        end
        default:
          nxt_key = KEY_IDLE;
      endcase
    end
  end

  wire progAllowed = pwdata[BIT_PROG_EN];
  // Write start only after unlock, enabled, flash space, idle
  wire launch = wrCtrl & pwdata[BIT_WRITE_START] & (key_ff == KEY_ARMED)
    & ~busy & progAllowed & ~pwdata[BIT_CFG_SEL];
  wire opErase = pwdata[BIT_ERASE_EN];
  wire opLatch = ~pwdata[BIT_ERASE_EN] & pwdata[BIT_LATCH_ONLY];
  // Protected erase or row write is refused
  wire protHit = launch & ~opLatch & writeProtect;
  wire doLatch = launch & opLatch;
  wire doErase = launch & opErase & ~protHit;
  wire doRow = launch & ~opErase & ~opLatch & ~protHit;
  // Read start can only be set
  wire doRead = wrCtrl & pwdata[BIT_READ_START] & ~busy & ~readStart_ff;
  wire errorSet = keyAbort | protHit | (firstCycle_ff & writeAbortedAtReset);
  wire opFinish = busy & flashDone;

  // Reset history is sampled once after release.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      firstCycle_ff <= 1'b1;
    else
      firstCycle_ff <= 1'b0;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      key_ff <= KEY_IDLE;
    else
      key_ff <= nxt_key;
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      adrLow_ff <= ADDR_LOW_RESET;
    else if (apbWrite && hitAdrLow)
      adrLow_ff <= pwdata[7:0];
  end

  // High address bits 14 to 8
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      adrHigh_ff <= ADDR_HIGH_RESET;
    else if (apbWrite && hitAdrHigh)
      adrHigh_ff <= pwdata[6:0];
  end

  // Plain control bits are held still while an operation runs.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfgSel_ff <= 1'b0;
      latchOnly_ff <= 1'b0;
      progEn_ff <= 1'b0;
    end
    else if (wrCtrl && !busy)
    begin
      cfgSel_ff <= pwdata[BIT_CFG_SEL];
      latchOnly_ff <= pwdata[BIT_LATCH_ONLY];
      progEn_ff <= pwdata[BIT_PROG_EN];
    end
  end

  // Erase enable cleared by hardware when the erase ends
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      eraseEn_ff <= 1'b0;
    else if (opFinish && state_ff == ST_ERASE)
      eraseEn_ff <= 1'b0;
    else if (wrCtrl && !busy)
      eraseEn_ff <= pwdata[BIT_ERASE_EN];
  end

  // A hardware set wins over a software clear in the same cycle.
  // Hardware only sets; software may write either value
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      error_ff <= 1'b0;
    else if (errorSet)
      error_ff <= 1'b1;
    else if (wrCtrl)
      error_ff <= pwdata[BIT_ERROR];
  end

  // A latch load ends in its own write edge, so write start never shows it.
  // Write start self-clears; zero writes are ignored
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      writeStart_ff <= 1'b0;
    else if (doErase || doRow)
      writeStart_ff <= 1'b1;
    else if (opFinish && (state_ff == ST_ERASE || state_ff == ST_ROW))
      writeStart_ff <= 1'b0;
  end

  // Read start clears when the data has arrived
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      readStart_ff <= 1'b0;
    else if (doRead)
      readStart_ff <= 1'b1;
    else if (opFinish && state_ff == ST_READ)
      readStart_ff <= 1'b0;
  end

  // Operation sequencer.
  // One operation at a time; a done pulse while idle is ignored.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      state_ff <= ST_IDLE;
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (doErase)
            state_ff <= ST_ERASE;
          else if (doRow)
            state_ff <= ST_ROW;
          else if (doRead)
            state_ff <= ST_READ;
        end
        ST_READ, ST_ERASE, ST_ROW:
        begin
          if (flashDone)
            state_ff <= ST_IDLE;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // Address and space are frozen at launch for the whole request.
  // Space select steers the flash request
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      flashReq_ff <= 1'b0;
      flashCmd_ff <= CMD_NONE;
      flashCfg_ff <= 1'b0;
      flashAddr_ff <= '0;
    end
    else if (doErase || doRow || doRead)
    begin
      flashReq_ff <= 1'b1;
      flashCmd_ff <= doErase ? CMD_ERASE : (doRow ? CMD_ROW_WRITE : CMD_READ);
      flashCfg_ff <= pwdata[BIT_CFG_SEL];
      flashAddr_ff <= {adrHigh_ff, adrLow_ff};
    end
    else if (opFinish)
    begin
      flashReq_ff <= 1'b0;
      flashCmd_ff <= CMD_NONE;
    end
  end

  // A finishing read wins over a software write in the same cycle.
  // Data registers take read data; 14-bit word
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      datLow_ff <= DATA_LOW_RESET;
      datHigh_ff <= DATA_HIGH_RESET;
    end
    else if (opFinish && state_ff == ST_READ)
    begin
      datLow_ff <= flashRdData[7:0];
      datHigh_ff <= flashRdData[WORD_W-1:8];
    end
    else if (apbWrite && hitDatLow)
      datLow_ff <= pwdata[7:0];
    else if (apbWrite && hitDatHigh)
      datHigh_ff <= pwdata[5:0];
  end

  // Latch load and latch reset after a row write
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      latch_ff <= {ROW_WORDS{LATCH_RESET_VAL}};
    else if (opFinish && state_ff == ST_ROW)
      latch_ff <= {ROW_WORDS{LATCH_RESET_VAL}};
    else if (doLatch)
      latch_ff[latchIdx] <= {datHigh_ff, datLow_ff};
  end

  // Read mux: top address bit one; control top bit zero.
  // Error reads zero while a write runs.
  wire [7:0] ctrlRead = {1'b0, cfgSel_ff, latchOnly_ff, eraseEn_ff,
    error_ff & ~writeStart_ff, progEn_ff, writeStart_ff, readStart_ff};
  // Unmapped and write-only offsets read as zero.
  wire [7:0] readByte =
    hitAdrLow ? adrLow_ff :
    hitAdrHigh ? {1'b1, adrHigh_ff} :
    hitCtrl ? ctrlRead :
    hitDatLow ? datLow_ff :
    hitDatHigh ? {2'b00, datHigh_ff} : 8'h00;

  // Read data is taken in the setup cycle so it stands through the access.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      prdata_ff <= 32'h0000_0000;
    else if (apbSetupRead)
      prdata_ff <= {24'h00_0000, readByte};
  end

  assign prdata = prdata_ff;
  // Every register answers at once, so no wait states are inserted.
  assign pready = 1'b1;
  assign pslverr = apbAccess & ~mapped;
  assign flashReq = flashReq_ff;
  assign flashCmd = flashCmd_ff;
  assign flashCfgSpace = flashCfg_ff;
  assign flashAddr = flashAddr_ff;
  assign flashRowData = latch_ff;

endmodule // npc_nvm_ctrl

//--- testbench/npc_nvm_properties.sv
// Port checker for the flash program and erase controller.
// Assumes a bind onto npc_nvm_ctrl, with every input named as its port.
module npc_props (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Flash array
  input wire logic flashReq,
  input wire logic [1:0] flashCmd,
  input wire logic flashCfgSpace,
  input wire logic [npc_pkg::ADDR_W-1:0] flashAddr,
  input wire npc_pkg::npc_row_t flashRowData,
  input wire logic flashDone,
  input wire logic writeProtect
);
  timeunit 1ns;
  timeprecision 1ps;
  import npc_pkg::*;
  wire acc = psel && penable;
  wire rdAcc = acc && !pwrite;
  wire ctlW = acc && pwrite && paddr == OFS_OP_CONTROL;
  wire keyW = acc && pwrite && paddr == OFS_UNLOCK_KEY;
  wire startW = ctlW && pwdata[1] && pwdata[2] && !pwdata[0] && !flashReq;
  logic saw55_ff;
  logic armed_ff;
  logic ok_ff;
  logic [7:0] wd_ff;
  // Tracks the key sequence and the last control word written.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      saw55_ff <= 1'b0;
      armed_ff <= 1'b0;
      ok_ff <= 1'b0;
      wd_ff <= 8'h00;
    end
    else if (acc)
    begin
      saw55_ff <= keyW && pwdata[7:0] == KEY_FIRST_VAL;
      armed_ff <= keyW && saw55_ff && pwdata[7:0] == KEY_SECOND_VAL;
      ok_ff <= ctlW && armed_ff;
      if (ctlW)
        wd_ff <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence launchS;
    $rose(flashReq) && flashCmd != CMD_READ;
  endsequence
  AST_UNLOCK: assert property (launchS |-> ok_ff)
    else $error("write launched without unlock");
  AST_PROG_EN: assert property (launchS |-> wd_ff[2])
    else $error("write launched with program enable low");
  AST_ERASE_WINS: assert property (launchS and wd_ff[4] |->
    flashCmd == CMD_ERASE) else $error("erase not issued");
  AST_ROW_CMD: assert property (launchS and !wd_ff[4] |->
    flashCmd == CMD_ROW_WRITE && !wd_ff[5]) else $error("bad row write");
  AST_SPACE: assert property ($rose(flashReq) |->
    flashCfgSpace == wd_ff[6] && (flashCmd == CMD_READ || !wd_ff[6]))
    else $error("wrong space selected");
  AST_HOLD: assert property (flashReq && !flashDone |=> flashReq &&
    $stable(flashCmd) && $stable(flashAddr)) else $error("request moved");
  AST_DONE: assert property (flashReq && flashDone |=> !flashReq)
    else $error("request kept after done");
  AST_LATCH_RST: assert property (flashReq && flashDone &&
    flashCmd == CMD_ROW_WRITE |=> flashRowData == {32{LATCH_RESET_VAL}})
    else $error("latches not reset");
  AST_PROTECT: assert property (startW && !pwdata[5] && writeProtect
    |=> !flashReq) else $error("protected row launched");
  AST_LATCH_ONLY: assert property (startW && pwdata[5] && !pwdata[4]
    |=> !flashReq) else $error("latch load touched array");
  AST_ADDR_HIGH: assert property (rdAcc && paddr == OFS_ADDR_HIGH
    |-> prdata[7]) else $error("address high top bit low");
  AST_CTRL_TOP: assert property (rdAcc && paddr == OFS_OP_CONTROL
    |-> !prdata[7]) else $error("control top bit high");
endmodule // npc_props

//--- testbench/npc_flash_model.sv
// Behavioural flash array that ends each request after doneDelay cycles.
// Assumes the controller holds flashReq until it has seen flashDone.
module npc_flash_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Requests
  input wire logic flashReq,
  input wire logic [1:0] flashCmd,
  input wire logic [npc_pkg::ADDR_W-1:0] flashAddr,
  input wire logic [4:0] doneDelay,
  // Answers
  output logic flashDone,
  output logic [npc_pkg::WORD_W-1:0] flashRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  import npc_pkg::*;
  logic [4:0] cnt_ff;
  logic seen_ff;
  // Read data toggles outside its cycle so a late sample is caught.
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_ff <= 5'h00;
      seen_ff <= 1'b0;
      flashDone <= 1'b0;
      flashRdData <= 14'h0000;
    end
    else
    begin
      flashDone <= 1'b0;
      flashRdData <= ~flashRdData;
      if (!flashReq)
      begin
        seen_ff <= 1'b0;
        cnt_ff <= 5'h00;
      end
      else if (!seen_ff && cnt_ff >= doneDelay)
      begin
        flashDone <= 1'b1;
        seen_ff <= 1'b1;
        if (flashCmd == CMD_READ)
          flashRdData <= ~flashAddr[13:0];
      end
      else
        cnt_ff <= cnt_ff + 5'h01;
    end
  end
endmodule // npc_flash_model

//--- testbench/tb.sv
// Self-checking bench for the flash controller, driven over APB.
// Assumes the flash model answers after the delay the bench sets.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import npc_pkg::*;
  logic mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, flashReq, flashCfgSpace, flashDone;
  logic writeProtect = 0, waReset = 0;
  logic [1:0] flashCmd;
  logic [ADDR_W-1:0] flashAddr;
  logic [WORD_W-1:0] flashRdData, w;
  logic [4:0] doneDelay = 5'h01;
  logic [7:0] a;
  npc_row_t flashRowData, row;
  int seed = 12, fail_count = 0, n_compared = 0, i;
  always #4 mclk = ~mclk;
  npc_nvm_ctrl i_npc_nvm_ctrl (.mclk(mclk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flashReq(flashReq), .flashCmd(flashCmd), .flashCfgSpace(flashCfgSpace),
    .flashAddr(flashAddr), .flashRowData(flashRowData),
    .flashDone(flashDone), .flashRdData(flashRdData),
    .writeProtect(writeProtect), .writeAbortedAtReset(waReset));
  npc_flash_model i_npc_flash_model (.mclk(mclk), .rstn(rstn),
    .flashReq(flashReq), .flashCmd(flashCmd), .flashAddr(flashAddr),
    .doneDelay(doneDelay), .flashDone(flashDone),
    .flashRdData(flashRdData));
  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] ad,
    input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge mclk);
      if (pready === 1'b1)
        break;
    end
    if (k == 20)
    begin
      fail_count++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [11:0] ad, input logic [31:0] e);
    bus(1'b0, ad, 32'h00000000);
    check(rd, e);
  endtask
  task automatic unlock(input logic [7:0] c);
    bus(1'b1, OFS_UNLOCK_KEY, 32'h00000055);
    bus(1'b1, OFS_UNLOCK_KEY, 32'h000000AA);
    bus(1'b1, OFS_OP_CONTROL, {24'h000000, c});
  endtask
  task automatic waitIdle();
    int k;
    @(negedge mclk);
    for (k = 0; k < 60 && flashReq !== 1'b0; k++)
      @(negedge mclk);
    if (k == 60)
    begin
      fail_count++;
      test_done();
    end
  endtask
  initial
  begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    rc(OFS_ADDR_LOW, 32'h00000000);
    rc(OFS_ADDR_HIGH, 32'h00000080);
    rc(OFS_OP_CONTROL, 32'h00000000);
    rc(OFS_DATA_HIGH, 32'h00000000);
    rc(12'h018, 32'h00000000);
    check(err, 32'h00000001);
    for (i = 0; i < 8; i++)
    begin
      a = 8'($random(seed));
      bus(1'b1, OFS_ADDR_HIGH, {24'h000000, a});
      rc(OFS_ADDR_HIGH, {24'h000000, 1'b1, a[6:0]});
      bus(1'b1, OFS_DATA_HIGH, {24'h000000, a});
      rc(OFS_DATA_HIGH, {26'h0000000, a[5:0]});
      bus(1'b1, OFS_ADDR_LOW, {24'h000000, ~a});
      rc(OFS_ADDR_LOW, {24'h000000, ~a});
    end
    doneDelay <= 5'($random(seed));
    bus(1'b1, OFS_OP_CONTROL, 32'h00000001);
    waitIdle();
    rc(OFS_DATA_LOW, {24'h000000, a});
    rc(OFS_DATA_HIGH, {26'h0000000, ~a[5:0]});
    rc(OFS_OP_CONTROL, 32'h00000000);
    bus(1'b1, OFS_ADDR_HIGH, 32'h00000012);
    for (i = 0; i < 32; i++)
    begin
      w = 14'($random(seed));
      row[i] = w;
      bus(1'b1, OFS_ADDR_LOW, 32'h000000E0 + i);
      bus(1'b1, OFS_DATA_LOW, {24'h000000, w[7:0]});
      bus(1'b1, OFS_DATA_HIGH, {26'h0000000, w[13:8]});
      unlock(8'h26);
    end
    doneDelay <= 5'h14;
    unlock(8'h06);
    @(negedge mclk);
    check(flashCmd, CMD_ROW_WRITE);
    check(flashRowData === row, 32'h00000001);
    check(flashAddr, 15'h12FF);
    bus(1'b1, OFS_OP_CONTROL, 32'h00000004);
    rc(OFS_OP_CONTROL, 32'h00000006);
    waitIdle();
    rc(OFS_OP_CONTROL, 32'h00000004);
    check(flashRowData === {32{LATCH_RESET_VAL}}, 32'h00000001);
    unlock(8'h36);
    @(negedge mclk);
    check(flashCmd, CMD_ERASE);
    waitIdle();
    rc(OFS_OP_CONTROL, 32'h00000024);
    bus(1'b1, OFS_UNLOCK_KEY, 32'h00000055);
    bus(1'b0, OFS_DATA_LOW, 32'h00000000);
    rc(OFS_OP_CONTROL, 32'h0000002C);
    bus(1'b1, OFS_OP_CONTROL, 32'h00000004);
    rc(OFS_OP_CONTROL, 32'h00000004);
    bus(1'b1, OFS_OP_CONTROL, 32'h0000000C);
    rc(OFS_OP_CONTROL, 32'h0000000C);
    writeProtect <= 1'b1;
    bus(1'b1, OFS_OP_CONTROL, 32'h00000004);
    unlock(8'h06);
    rc(OFS_OP_CONTROL, 32'h0000000C);
    writeProtect <= 1'b0;
    bus(1'b1, OFS_OP_CONTROL, 32'h00000000);
    unlock(8'h02);
    rc(OFS_OP_CONTROL, 32'h00000000);
    unlock(8'h46);
    rc(OFS_OP_CONTROL, 32'h00000044);
    check(flashReq, 32'h00000000);
    bus(1'b1, OFS_OP_CONTROL, 32'h00000041);
    @(negedge mclk);
    check(flashCfgSpace, 32'h00000001);
    check(flashCmd, CMD_READ);
    waitIdle();
    @(posedge mclk);
    waReset <= 1'b1;
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    waReset <= 1'b0;
    rc(OFS_OP_CONTROL, 32'h00000008);
    test_done();
  end
endmodule // tb
bind npc_nvm_ctrl npc_props i_npc_props (.mclk(mclk), .rstn(rstn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .flashReq(flashReq),
  .flashCmd(flashCmd), .flashCfgSpace(flashCfgSpace),
  .flashAddr(flashAddr), .flashRowData(flashRowData),
  .flashDone(flashDone), .writeProtect(writeProtect));
